/* hw/anbp_map.svh */
`ifndef ANBP_MAP_SVH
`define ANBP_MAP_SVH

// -----------------------------------------------------------------------------
// widths
// -----------------------------------------------------------------------------
`define ANBP_ADDR_W 19
`define ANBP_DATA_W 8
`define ANBP_CNT_W 8
`define ANBP_BOOT_W 22

// -----------------------------------------------------------------------------
// timing in ns at a 10 ns clock, start-up in ms
// -----------------------------------------------------------------------------
`define ANBP_CLK_NS 10
`define ANBP_CYCLE_TIME_NS 35
`define ANBP_READ_ACCESS_NS 35
`define ANBP_OE_ACCESS_NS 15
`define ANBP_OE_FLOAT_NS 10
`define ANBP_ADDR_TO_END_NS 20
`define ANBP_STROBE_WIDTH_NS 15
`define ANBP_DATA_SETUP_TO_END_NS 10
`define ANBP_WRITE_RECOVERY_NS 12
`define ANBP_HIGH_MIN_NS 2
`define ANBP_STARTUP_MS 2

// least times round up, access maxima are waits so they round up too
`define ANBP_CEIL(t) (((t) + `ANBP_CLK_NS - 1) / `ANBP_CLK_NS)
`define ANBP_READ_WAIT_CYC `ANBP_CEIL(`ANBP_READ_ACCESS_NS)
`define ANBP_OE_WAIT_CYC `ANBP_CEIL(`ANBP_OE_ACCESS_NS)
`define ANBP_FLOAT_CYC `ANBP_CEIL(`ANBP_OE_FLOAT_NS)
`define ANBP_STROBE_CYC `ANBP_CEIL(`ANBP_ADDR_TO_END_NS)
`define ANBP_RECOVERY_CYC `ANBP_CEIL(`ANBP_WRITE_RECOVERY_NS)
`define ANBP_HIGH_CYC `ANBP_CEIL(`ANBP_HIGH_MIN_NS)
`define ANBP_CYCLE_CYC `ANBP_CEIL(`ANBP_CYCLE_TIME_NS)
// pin flops a byte passes before it counts, added to the read wait
`define ANBP_SYNC_CYC 3
`define ANBP_STARTUP_CYC ((`ANBP_STARTUP_MS * 1000000) / `ANBP_CLK_NS)

`endif

/* hw/anbp_pkg.sv */
package anbp_pkg;

  // ---------------------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ANBP_STARTUP = 3'b000,
    ANBP_IDLE = 3'b001,
    ANBP_RD_ACCESS = 3'b010,
    ANBP_RD_FLOAT = 3'b011,
    ANBP_WR_STROBE = 3'b100,
    ANBP_WR_RECOVER = 3'b101,
    ANBP_GAP = 3'b110
  } anbp_state_e;

endpackage : anbp_pkg

/* hw/anbp_sync.sv */
`include "anbp_map.svh"

module anbp_sync (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [`ANBP_DATA_W-1:0] i_async,
  output logic [`ANBP_DATA_W-1:0] o_sync
);

  // ---------------------------------------------------------------------------
  // three stages per bit, a change counts when stages two and three agree
  // ---------------------------------------------------------------------------
  logic [`ANBP_DATA_W-1:0] s1;
  logic [`ANBP_DATA_W-1:0] s2;
  logic [`ANBP_DATA_W-1:0] s3;
  logic [`ANBP_DATA_W-1:0] held;
  logic [`ANBP_DATA_W-1:0] next_held;

  genvar g;
  generate
    for (g = 0; g < `ANBP_DATA_W; g++)
    begin : g_bit
      always_comb
      begin
        next_held[g] = (s2[g] == s3[g]) ? s3[g] : held[g];
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      held <= '0;
    end
    else
    begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      held <= next_held;
    end
  end

  assign o_sync = held;

endmodule : anbp_sync

/* hw/anbp_ctrl.sv */
`include "anbp_map.svh"

module anbp_ctrl #(
  parameter int STARTUP_CYC = `ANBP_STARTUP_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [`ANBP_ADDR_W-1:0] i_addr,
  input wire logic [`ANBP_DATA_W-1:0] i_wdata,
  output logic o_ready,
  output logic o_rvalid,
  output logic [`ANBP_DATA_W-1:0] o_rdata,
  output logic [`ANBP_ADDR_W-1:0] o_mem_addr,
  output logic o_mem_sel_n,
  output logic o_mem_wr_n,
  output logic o_mem_oe_n,
  input wire logic [`ANBP_DATA_W-1:0] i_mem_dq,
  output logic [`ANBP_DATA_W-1:0] o_mem_dq,
  output logic o_mem_dq_oe
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  anbp_pkg::anbp_state_e state;
  anbp_pkg::anbp_state_e next_state;
  logic [`ANBP_BOOT_W-1:0] boot_cnt;
  logic [`ANBP_BOOT_W-1:0] next_boot_cnt;
  logic [`ANBP_CNT_W-1:0] cnt;
  logic [`ANBP_CNT_W-1:0] next_cnt;
  logic [`ANBP_CNT_W-1:0] gap_cnt;
  logic [`ANBP_CNT_W-1:0] next_gap_cnt;
  logic ready;
  logic next_ready;
  logic rvalid;
  logic next_rvalid;
  logic [`ANBP_DATA_W-1:0] rdata;
  logic [`ANBP_DATA_W-1:0] next_rdata;
  logic [`ANBP_ADDR_W-1:0] addr;
  logic [`ANBP_ADDR_W-1:0] next_addr;
  logic sel_n;
  logic next_sel_n;
  logic wr_n;
  logic next_wr_n;
  logic oe_n;
  logic next_oe_n;
  logic [`ANBP_DATA_W-1:0] dq;
  logic [`ANBP_DATA_W-1:0] next_dq;
  logic dq_oe;
  logic next_dq_oe;
  logic [`ANBP_DATA_W-1:0] dq_in;

  localparam logic [`ANBP_CNT_W-1:0] RD_WAIT = `ANBP_CNT_W'(`ANBP_READ_WAIT_CYC + `ANBP_SYNC_CYC);
  localparam logic [`ANBP_CNT_W-1:0] FLOAT_WAIT = `ANBP_CNT_W'(`ANBP_FLOAT_CYC);
  localparam logic [`ANBP_CNT_W-1:0] STB_WAIT = `ANBP_CNT_W'(`ANBP_STROBE_CYC);
  localparam logic [`ANBP_CNT_W-1:0] REC_WAIT = `ANBP_CNT_W'(`ANBP_RECOVERY_CYC);
  localparam logic [`ANBP_CNT_W-1:0] HIGH_WAIT = `ANBP_CNT_W'(`ANBP_HIGH_CYC);
  localparam logic [`ANBP_CNT_W-1:0] CYC_WAIT = `ANBP_CNT_W'(`ANBP_CYCLE_CYC);
  localparam logic [`ANBP_BOOT_W-1:0] BOOT_LAST = `ANBP_BOOT_W'(STARTUP_CYC - 1);

  // ---------------------------------------------------------------------------
  // read data capture from the pins
  // ---------------------------------------------------------------------------
  anbp_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_mem_dq),
    .o_sync(dq_in)
  );

  // ---------------------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_boot_cnt = boot_cnt;
    next_cnt = cnt;
    next_gap_cnt = (gap_cnt != '0) ? gap_cnt - `ANBP_CNT_W'(1) : gap_cnt;
    next_ready = 1'b0;
    next_rvalid = 1'b0;
    next_rdata = rdata;
    next_addr = addr;
    next_sel_n = sel_n;
    next_wr_n = 1'b1;
    next_oe_n = oe_n;
    next_dq = dq;
    next_dq_oe = dq_oe;
    case (state)
      anbp_pkg::ANBP_STARTUP:
      begin
        next_sel_n = 1'b1;
        if (boot_cnt == BOOT_LAST)
        begin
          next_state = anbp_pkg::ANBP_IDLE;
          next_ready = 1'b1;
        end
        else
        begin
          next_boot_cnt = boot_cnt + `ANBP_BOOT_W'(1);
        end
      end
      anbp_pkg::ANBP_IDLE:
      begin
        next_ready = 1'b1;
        if (i_req && ready && gap_cnt == '0)
        begin
          next_ready = 1'b0;
          next_addr = i_addr;
          next_sel_n = 1'b0;
          next_gap_cnt = CYC_WAIT - `ANBP_CNT_W'(1);
          if (i_we)
          begin
            next_wr_n = 1'b0;
            next_oe_n = 1'b1;
            next_dq = i_wdata;
            next_dq_oe = 1'b1;
            next_cnt = STB_WAIT;
            next_state = anbp_pkg::ANBP_WR_STROBE;
          end
          else
          begin
            next_oe_n = 1'b0;
            next_cnt = RD_WAIT;
            next_state = anbp_pkg::ANBP_RD_ACCESS;
          end
        end
      end
      anbp_pkg::ANBP_RD_ACCESS:
      begin
        next_cnt = cnt - `ANBP_CNT_W'(1);
        // pin synchroniser adds three cycles past the access time
        if (cnt == '0)
        begin
          next_rdata = dq_in;
          next_rvalid = 1'b1;
          next_sel_n = 1'b1;
          next_oe_n = 1'b1;
          next_cnt = FLOAT_WAIT;
          next_state = anbp_pkg::ANBP_RD_FLOAT;
        end
      end
      anbp_pkg::ANBP_RD_FLOAT:
      begin
        next_cnt = cnt - `ANBP_CNT_W'(1);
        if (cnt == '0)
        begin
          next_cnt = HIGH_WAIT;
          next_state = anbp_pkg::ANBP_GAP;
        end
      end
      anbp_pkg::ANBP_WR_STROBE:
      begin
        next_wr_n = 1'b0;
        next_cnt = cnt - `ANBP_CNT_W'(1);
        if (cnt == '0)
        begin
          next_wr_n = 1'b1;
          next_sel_n = 1'b1;
          next_cnt = REC_WAIT;
          next_state = anbp_pkg::ANBP_WR_RECOVER;
        end
      end
      anbp_pkg::ANBP_WR_RECOVER:
      begin
        next_cnt = cnt - `ANBP_CNT_W'(1);
        if (cnt == '0)
        begin
          next_dq_oe = 1'b0;
          next_cnt = HIGH_WAIT;
          next_state = anbp_pkg::ANBP_GAP;
        end
      end
      anbp_pkg::ANBP_GAP:
      begin
        next_cnt = cnt - `ANBP_CNT_W'(1);
        if (cnt == '0)
        begin
          next_ready = 1'b1;
          next_state = anbp_pkg::ANBP_IDLE;
        end
      end
      default:
      begin
        next_state = anbp_pkg::ANBP_STARTUP;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= anbp_pkg::ANBP_STARTUP;
      boot_cnt <= '0;
      cnt <= '0;
      gap_cnt <= '0;
      ready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      addr <= '0;
      sel_n <= 1'b1;
      wr_n <= 1'b1;
      oe_n <= 1'b1;
      dq <= '0;
      dq_oe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      boot_cnt <= next_boot_cnt;
      cnt <= next_cnt;
      gap_cnt <= next_gap_cnt;
      ready <= next_ready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      addr <= next_addr;
      sel_n <= next_sel_n;
      wr_n <= next_wr_n;
      oe_n <= next_oe_n;
      dq <= next_dq;
      dq_oe <= next_dq_oe;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs, all from flops
  // ---------------------------------------------------------------------------
  assign o_ready = ready;
  assign o_rvalid = rvalid;
  assign o_rdata = rdata;
  assign o_mem_addr = addr;
  assign o_mem_sel_n = sel_n;
  assign o_mem_wr_n = wr_n;
  assign o_mem_oe_n = oe_n;
  assign o_mem_dq = dq;
  assign o_mem_dq_oe = dq_oe;

endmodule : anbp_ctrl

/* bench/anbp_ctrl_props.sv */
`include "anbp_map.svh"

module anbp_ctrl_props #(
  parameter int STARTUP_CYC = 20
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [`ANBP_ADDR_W-1:0] i_addr,
  input wire logic [`ANBP_DATA_W-1:0] i_wdata,
  input wire logic o_ready,
  input wire logic o_rvalid,
  input wire logic [`ANBP_DATA_W-1:0] o_rdata,
  input wire logic [`ANBP_ADDR_W-1:0] o_mem_addr,
  input wire logic o_mem_sel_n,
  input wire logic o_mem_wr_n,
  input wire logic o_mem_oe_n,
  input wire logic [`ANBP_DATA_W-1:0] i_mem_dq,
  input wire logic [`ANBP_DATA_W-1:0] o_mem_dq,
  input wire logic o_mem_dq_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // ---------------------------------------------------------------------------
  // helpers: start-up edge count, last taken write
  // ---------------------------------------------------------------------------
  int cnt;
  int next_cnt;
  logic [`ANBP_ADDR_W-1:0] wa;
  logic [`ANBP_DATA_W-1:0] wd;
  always_comb next_cnt = (cnt < STARTUP_CYC) ? cnt + 1 : cnt;
  always_ff @(posedge i_ref_clk or negedge i_reset_n)
    if (!i_reset_n) cnt <= 0;
    else cnt <= next_cnt;
  // no reset: only read after a take has loaded them
  always_ff @(posedge i_ref_clk)
    if (i_req && o_ready && i_we) {wa, wd} <= {i_addr, i_wdata};
  a_startup_idle: assert property (cnt < STARTUP_CYC |-> o_mem_sel_n && o_mem_wr_n && !o_ready)
    else $error("select or strobe active in start-up");
  a_write_pins: assert property ($fell(o_mem_wr_n) |-> !o_mem_sel_n && o_mem_dq_oe && o_mem_addr == wa && o_mem_dq == wd)
    else $error("write strobe without taken address and data");
  a_strobe_overlap: assert property ($fell(o_mem_wr_n) |=> !o_mem_wr_n && !o_mem_sel_n)
    else $error("write overlap too short");
  a_oe_off_write: assert property (!o_mem_wr_n |-> o_mem_oe_n && !o_mem_sel_n)
    else $error("enable low or select high during write strobe");
  a_read_strobe: assert property (!o_mem_oe_n |-> o_mem_wr_n && !o_mem_dq_oe)
    else $error("strobe or data drive during read");
  a_read_answer: assert property ($fell(o_mem_sel_n) && !o_mem_oe_n |-> (!o_rvalid)[*8] ##1 o_rvalid)
    else $error("read data captured too early or never");
  a_addr_held: assert property (!o_mem_sel_n && !$past(o_mem_sel_n) |-> $stable(o_mem_addr))
    else $error("address moved while selected");
  a_write_tail: assert property ($rose(o_mem_wr_n) |-> (o_mem_dq_oe && $stable(o_mem_dq) && $stable(o_mem_addr))[*2])
    else $error("address or data not held around write end");
  a_sel_gap: assert property ($fell(o_mem_sel_n) |=> (!$fell(o_mem_sel_n))[*3])
    else $error("select falls closer than cycle time");
  a_high_min: assert property ($rose(o_mem_sel_n) |=> o_mem_sel_n && o_mem_wr_n)
    else $error("select or strobe high too briefly");
endmodule : anbp_ctrl_props

bind anbp_ctrl anbp_ctrl_props #(.STARTUP_CYC(STARTUP_CYC)) u_props (.*);

/* bench/anbp_mem_model.sv */
`include "anbp_map.svh"

module anbp_mem_model (
  input wire logic [`ANBP_ADDR_W-1:0] i_addr,
  input wire logic i_sel_n,
  input wire logic i_wr_n,
  input wire logic i_oe_n,
  input wire logic [`ANBP_DATA_W-1:0] i_dq,
  output logic [`ANBP_DATA_W-1:0] o_dq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------------------
  // array, access delay, released-bus pattern
  // ---------------------------------------------------------------------------
  logic [`ANBP_DATA_W-1:0] mem [logic [`ANBP_ADDR_W-1:0]];
  int acc_ns = 35;
  logic alive = 1'b0;
  logic ok = 1'b0;
  logic tgl = 1'b0;
  logic on;
  initial #300 alive = 1'b1;
  always #5 tgl = ~tgl;
  // floats at once: no stale byte for the simulator to settle on
  assign on = !i_sel_n && !i_oe_n && i_wr_n;
  always @(i_addr or on)
  begin
    ok = 1'b0;
    #(acc_ns) ok = on;
  end
  assign o_dq = (on && ok && alive) ? mem[i_addr] : {8{tgl}};
  always @(posedge (i_sel_n | i_wr_n))
    if (alive) mem[i_addr] = i_dq;
endmodule : anbp_mem_model

/* bench/async_nvram_byte_port_bench.sv */
`include "anbp_map.svh"

module async_nvram_byte_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SC = 20;
  typedef struct {logic we; logic [18:0] a; logic [7:0] d;} anbp_row_s;
  logic i_ref_clk = 1'b0, i_reset_n = 1'b0, i_req = 1'b0, i_we = 1'b0;
  logic [`ANBP_ADDR_W-1:0] i_addr = 19'h0, o_mem_addr;
  logic [`ANBP_DATA_W-1:0] i_wdata = 8'h0, o_rdata, i_mem_dq, o_mem_dq, mem_dq;
  logic o_ready, o_rvalid, o_mem_sel_n, o_mem_wr_n, o_mem_oe_n, o_mem_dq_oe;
  int n_errors = 0, checked = 0, cyc = 0, n;
  anbp_row_s rows [8] = '{'{1'b1, 19'h0, 8'h5a}, '{1'b1, 19'h7ffff, 8'ha5}, '{1'b1, 19'h12345, 8'h3c},
    '{1'b0, 19'h0, 8'h5a}, '{1'b0, 19'h7ffff, 8'ha5}, '{1'b0, 19'h12345, 8'h3c},
    '{1'b1, 19'h12345, 8'hc3}, '{1'b0, 19'h12345, 8'hc3}};
  anbp_ctrl #(.STARTUP_CYC(SC)) uut (.*);
  anbp_mem_model mem_u (.i_addr(o_mem_addr), .i_sel_n(o_mem_sel_n), .i_wr_n(o_mem_wr_n),
    .i_oe_n(o_mem_oe_n), .i_dq(i_mem_dq), .o_dq(mem_dq));
  assign i_mem_dq = o_mem_dq_oe ? o_mem_dq : mem_dq;
  initial forever #5 i_ref_clk = ~i_ref_clk;
  // ---------------------------------------------------------------------------
  // compares, reset, one host access
  // ---------------------------------------------------------------------------
  task automatic chk_bit(string nm, logic e, logic g);
    checked++;
    if (g !== e) $display("[ERR] %s expected %b seen %b", nm, e, g);
    if (g !== e) n_errors++;
  endtask : chk_bit
  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) $display("[ERR] %s expected %h seen %h", nm, e, g);
    if (g !== e) n_errors++;
  endtask : chk_byte
  task automatic chk_cnt(string nm, int e, int g);
    checked++;
    if (g != e) $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    if (g != e) n_errors++;
  endtask : chk_cnt
  task automatic results();
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task automatic do_reset();
    i_reset_n = 1'b0;
    repeat (12) @(posedge i_ref_clk);
    #1 chk_bit("sel_n", 1'b1, o_mem_sel_n);
    chk_bit("wr_n", 1'b1, o_mem_wr_n);
    i_reset_n = 1'b1;
    n = 0;
    while (o_ready !== 1'b1 && n < 100) @(posedge i_ref_clk) #1 n++;
    chk_cnt("startup", SC, n);
  endtask : do_reset
  // entered 1 ns after an edge; request held until an edge sees ready
  task automatic access(logic we, logic [18:0] a, logic [7:0] d);
    int k;
    {i_req, i_we, i_addr, i_wdata} = {1'b1, we, a, d};
    k = 0;
    while (o_ready !== 1'b1 && k < 100) @(posedge i_ref_clk) #1 k++;
    @(posedge i_ref_clk) #1 i_req = 1'b0;
    @(posedge i_ref_clk) #1 chk_bit("ready", 1'b0, o_ready);
    k = 0;
    while (!we && o_rvalid !== 1'b1 && k < 20) @(posedge i_ref_clk) #1 k++;
    if (!we) chk_bit("rvalid", 1'b1, o_rvalid);
    if (!we) chk_byte("rdata", d, o_rdata);
    @(posedge i_ref_clk) #1 chk_bit("rvalid", 1'b0, o_rvalid);
  endtask : access
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    do_reset();
    foreach (rows[i])
    begin
      mem_u.acc_ns = i[0] ? 35 : 5;
      access(rows[i].we, rows[i].a, rows[i].d);
    end
    // reset in mid-read: pins idle at once, stored byte survives
    {i_req, i_we, i_addr} = {1'b1, 1'b0, 19'h7ffff};
    while (o_mem_sel_n !== 1'b0) @(posedge i_ref_clk) #1;
    @(posedge i_ref_clk) #1 {i_req, i_reset_n} = 2'b00;
    #1 chk_bit("sel_n", 1'b1, o_mem_sel_n);
    chk_bit("oe_n", 1'b1, o_mem_oe_n);
    chk_bit("rvalid", 1'b0, o_rvalid);
    do_reset();
    access(1'b0, 19'h7ffff, 8'ha5);
    results();
  end
endmodule : async_nvram_byte_port_bench
